// File: rtl/swcsp_top.sv
// Functional notes
// - 16-bit serial words, daisy-chain capable
// - Direct input low off, high on
// - Rising direct input wakes from sleep
// - Load type low bulb, high motor
// - Floating load type reads as motor
// - Fault flag low on any fault
// - Per-fault bits cleared by reading them
// - Monitor PWM clock, flag its loss
// - PWM sets on-time and turn-on delay
// - Reset low holds config and read select at reset
// - Sleep after delay, reset and direct inputs low
// - Reset rising wakes, starts watchdog
// - First bit must toggle, else fail-safe
// - Transfer and output only while selected
// - Select rise latches word by address
// - Select fall loads one of eight
// - Both sense bits clear tri-state sense
// - Sense off during overcurrent window
// - Track-hold keeps pre-turn-off current
// - Sync low valid, rises at turn-off
// - Sync rise usable as sample event
// - Watchdog timeout nominally 310 ms
// - Sample on falling, shift on rising
// - Most significant bit first
// - Address field in bits 9 to 12
`timescale 1ns/1ps
`default_nettype none
module swcsp_top
  import swcsp_pkg::*;
#(
  parameter int WDTO_CYCLES = swcsp_pkg::WDTO_CYC,
  parameter int CLKMON_CYCLES = swcsp_pkg::CLKMON_CYC
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_wake_n,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  input wire logic [1:0] direct_in,
  input wire logic [1:0] load_type_select,
  input wire logic pwm_clock,
  input wire logic [swcsp_pkg::NFAULT-1:0] fault_events_ch0,
  input wire logic [swcsp_pkg::NFAULT-1:0] fault_events_ch1,
  input wire logic [1:0] overcur_window_active,
  input wire logic [1:0] pwm_ch_on,
  output logic [1:0] channel_on,
  output logic [1:0] motor_profile,
  output logic [1:0] sense_enable,
  output logic sense_track_hold,
  output logic sense_hold,
  output logic sense_oe,
  output logic fault_flag_n_out,
  output logic fault_flag_n_oe,
  output logic sync_out,
  output logic sync_oe,
  output logic failsafe,
  output logic asleep,
  output logic [15:0] global_config_reg
);
  import swcsp_pkg::*;
  localparam int WD_W = $clog2(WDTO_CYCLES + 1);
  localparam int CM_W = $clog2(CLKMON_CYCLES + 1);
  localparam int SL_W = $clog2(SLEEP_CYC + 1);
  localparam logic [WD_W-1:0] WD_MAX = WD_W'(WDTO_CYCLES - 1);
  localparam logic [CM_W-1:0] CM_MAX = CM_W'(CLKMON_CYCLES - 1);
  localparam logic [SL_W-1:0] SL_MAX = SL_W'(SLEEP_CYC - 1);
  localparam logic [CNT_W-1:0] LAST_BIT = CNT_W'(WORD_W - 1);

  // Pin inputs through two flip-flops; select enters inverted so reset reads it idle
  logic [6:0] pins_s;
  swcsp_sync #(.W(7)) u_sync (
    .clk(clk),
    .nrst(nrst),
    .d({reset_wake_n, ~chip_select_n, sclk, sdi, direct_in, pwm_clock}),
    .q(pins_s)
  );
  logic rst_s, cs_s, sck_s, sdi_s, pclk_s;
  logic [1:0] din_s;
  assign rst_s = pins_s[6];
  assign cs_s = ~pins_s[5];
  assign sck_s = pins_s[4];
  assign sdi_s = pins_s[3];
  assign din_s = pins_s[2:1];
  assign pclk_s = pins_s[0];

  typedef struct packed {
    logic rst_d;
    logic cs_d;
    logic sck_d;
    logic [1:0] din_d;
    logic pclk_d;
    logic [WORD_W-1:0] sh_in;
    logic [WORD_W-1:0] sh_out;
    logic [CNT_W-1:0] bits;
    logic [15:0] cfg;
    logic [NFAULT-1:0] flt0;
    logic [NFAULT-1:0] flt1;
    logic [2:0] rd_sel;
    logic wd_last;
    logic wd_armed;
    logic [WD_W-1:0] wd_cnt;
    logic [CM_W-1:0] cm_cnt;
    logic [SL_W-1:0] sl_cnt;
    swcsp_mode_t mode;
    logic [1:0] ch_on;
    logic hold;
    logic sync_low;
    logic sdo;
  } swcsp_state_t;

  swcsp_state_t st_ff, nxt_st;

  logic cs_fall, cs_rise, sck_fall, sck_rise, rst_rise, pclk_edge, any_fault;
  logic [1:0] din_rise;
  logic [1:0] ch_cmd;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] word_in;
  logic pwm_sel_0, pwm_sel_1;

  // Edge detection on synchronised pins
  assign cs_fall = st_ff.cs_d & ~cs_s;
  assign cs_rise = ~st_ff.cs_d & cs_s;
  assign sck_fall = st_ff.sck_d & ~sck_s;
  assign sck_rise = ~st_ff.sck_d & sck_s;
  assign rst_rise = ~st_ff.rst_d & rst_s;
  assign din_rise = ~st_ff.din_d & din_s;
  assign pclk_edge = st_ff.pclk_d ^ pclk_s;
  assign any_fault = |{st_ff.flt0, st_ff.flt1};
  assign pwm_sel_0 = st_ff.cfg[CFG_PWM0];
  assign pwm_sel_1 = st_ff.cfg[CFG_PWM1];
  // Channel command: PWM drives on-time and delay, else direct input
  assign ch_cmd[0] = pwm_sel_0 ? pwm_ch_on[0] : din_s[0];
  assign ch_cmd[1] = pwm_sel_1 ? pwm_ch_on[1] : din_s[1];

  // Read word chosen by the previous frame's address
  always_comb begin
    rd_word = '0;
    case (st_ff.rd_sel)
      RD_STATUS: rd_word = {4'h0, st_ff.flt0[F_OVERVOLT], st_ff.flt0[F_UNDERVOLT],
                            st_ff.flt0[F_CLK], st_ff.mode == SWCSP_FAILSAFE, 4'h0,
                            st_ff.ch_on, |st_ff.flt1, |st_ff.flt0};
      RD_FAULT0: rd_word = {7'h00, st_ff.flt0};
      RD_FAULT1: rd_word = {7'h00, st_ff.flt1};
      RD_DIAG: rd_word = {10'h000, st_ff.flt1[F_OPEN_OFF], st_ff.flt1[F_OPEN_ON],
                          st_ff.flt0[F_OPEN_OFF], st_ff.flt0[F_OPEN_ON], load_type_select};
      RD_CONFIG: rd_word = st_ff.cfg;
      default: rd_word = '0;
    endcase
  end

  assign word_in = st_ff.sh_in;

  // Next-state logic for the whole block
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rst_d = rst_s;
    nxt_st.cs_d = cs_s;
    nxt_st.sck_d = sck_s;
    nxt_st.din_d = din_s;
    nxt_st.pclk_d = pclk_s;
    // Fault capture, set wins over read clear
    if (cs_fall) begin
      case (st_ff.rd_sel)
        RD_STATUS: begin
          nxt_st.flt0[F_OVERVOLT] = 1'b0;
          nxt_st.flt0[F_UNDERVOLT] = 1'b0;
          nxt_st.flt0[F_CLK] = 1'b0;
        end
        RD_FAULT0: nxt_st.flt0 = '0;
        RD_FAULT1: nxt_st.flt1 = '0;
        RD_DIAG: begin
          nxt_st.flt0[F_OPEN_ON] = 1'b0;
          nxt_st.flt0[F_OPEN_OFF] = 1'b0;
          nxt_st.flt1[F_OPEN_ON] = 1'b0;
          nxt_st.flt1[F_OPEN_OFF] = 1'b0;
        end
        default: nxt_st.flt0 = st_ff.flt0;
      endcase
    end
    nxt_st.flt0 = nxt_st.flt0 | fault_events_ch0;
    nxt_st.flt1 = nxt_st.flt1 | fault_events_ch1;
    // External PWM clock monitor
    if (pclk_edge || !(pwm_sel_0 || pwm_sel_1)) begin
      nxt_st.cm_cnt = '0;
    end else if (st_ff.cm_cnt == CM_MAX) begin
      nxt_st.flt0[F_CLK] = 1'b1;
    end else begin
      nxt_st.cm_cnt = st_ff.cm_cnt + 1'b1;
    end
    // Serial shifting while selected
    if (!cs_s) begin
      if (cs_fall) begin
        nxt_st.sh_out = rd_word;
        nxt_st.bits = '0;
        nxt_st.sdo = rd_word[WORD_W-1];
      end else if (sck_fall) begin
        nxt_st.sh_in = {st_ff.sh_in[WORD_W-2:0], sdi_s};
        if (st_ff.bits != LAST_BIT) begin
          nxt_st.bits = st_ff.bits + 1'b1;
        end
      end else if (sck_rise && st_ff.bits != '0) begin
        nxt_st.sh_out = {st_ff.sh_out[WORD_W-2:0], st_ff.sh_in[0]};
        nxt_st.sdo = st_ff.sh_out[WORD_W-2];
      end
    end
    // Latch word on select rise
    if (cs_rise) begin
      nxt_st.rd_sel = word_in[ADDR_LO +: 3];
      if (word_in[ADDR_LO +: ADDR_W] == WR_CFG) begin
        nxt_st.cfg = word_in;
      end
      if (st_ff.wd_armed && word_in[WD_BIT] != st_ff.wd_last) begin
        nxt_st.wd_cnt = '0;
      end
      nxt_st.wd_last = word_in[WD_BIT];
    end
    // Watchdog timer
    if (st_ff.mode == SWCSP_NORMAL && st_ff.wd_armed && !cs_rise) begin
      if (st_ff.wd_cnt == WD_MAX) begin
        nxt_st.mode = SWCSP_FAILSAFE;
      end else begin
        nxt_st.wd_cnt = st_ff.wd_cnt + 1'b1;
      end
    end
    // Mode control
    case (st_ff.mode)
      SWCSP_SLEEP: begin
        if (rst_rise || |din_rise) begin
          nxt_st.mode = SWCSP_NORMAL;
        end
      end
      SWCSP_NORMAL, SWCSP_FAILSAFE: begin
        if (!rst_s && din_s == 2'b00) begin
          if (st_ff.sl_cnt == SL_MAX) begin
            nxt_st.mode = SWCSP_SLEEP;
          end else begin
            nxt_st.sl_cnt = st_ff.sl_cnt + 1'b1;
          end
        end else begin
          nxt_st.sl_cnt = '0;
        end
      end
      default: nxt_st.mode = SWCSP_SLEEP;
    endcase
    if (rst_rise) begin
      nxt_st.wd_armed = 1'b1;
      nxt_st.wd_cnt = '0;
      nxt_st.mode = SWCSP_NORMAL;
    end
    if (!rst_s) begin
      nxt_st.cfg = CFG_RST;
      nxt_st.rd_sel = RD_STATUS;
      nxt_st.wd_armed = 1'b0;
      nxt_st.wd_cnt = '0;
    end
    // Outputs; fail-safe falls back to direct inputs
    if (st_ff.mode == SWCSP_SLEEP) begin
      nxt_st.ch_on = 2'b00;
    end else if (st_ff.mode == SWCSP_FAILSAFE) begin
      nxt_st.ch_on = din_s;
    end else begin
      nxt_st.ch_on = ch_cmd;
    end
    // Track and hold, sync
    nxt_st.hold = st_ff.cfg[CFG_TRACK] & ~(|nxt_st.ch_on);
    nxt_st.sync_low = |(nxt_st.ch_on & sense_enable);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '{rst_d: 1'b0, cs_d: 1'b1, sck_d: 1'b0, din_d: 2'b00, pclk_d: 1'b0,
                 sh_in: '0, sh_out: '0, bits: '0, cfg: CFG_RST, flt0: '0, flt1: '0,
                 rd_sel: RD_STATUS, wd_last: 1'b0, wd_armed: 1'b0, wd_cnt: '0,
                 cm_cnt: '0, sl_cnt: '0, mode: SWCSP_SLEEP, ch_on: 2'b00, hold: 1'b0,
                 sync_low: 1'b0, sdo: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Pin and status outputs
  assign sdo = st_ff.sdo;
  assign sdo_oe = ~cs_s;
  assign channel_on = st_ff.ch_on;
  assign motor_profile = load_type_select;
  assign sense_enable = {st_ff.cfg[CFG_SENSE_HI], st_ff.cfg[CFG_SENSE_LO]}
                        & ~overcur_window_active;
  assign sense_oe = |sense_enable && st_ff.mode == SWCSP_NORMAL;
  assign sense_track_hold = st_ff.cfg[CFG_TRACK];
  assign sense_hold = st_ff.hold;
  assign fault_flag_n_out = 1'b0;
  assign fault_flag_n_oe = any_fault;
  assign sync_out = 1'b0;
  assign sync_oe = st_ff.sync_low;
  assign failsafe = st_ff.mode == SWCSP_FAILSAFE;
  assign asleep = st_ff.mode == SWCSP_SLEEP;
  assign global_config_reg = st_ff.cfg;
endmodule : swcsp_top
`default_nettype wire

// File: rtl/swcsp_pkg.sv
package swcsp_pkg;
  // Serial word layout
  localparam int WORD_W = 16;
  localparam int WD_BIT = 15;
  localparam int ADDR_LO = 9;
  localparam int ADDR_W = 4;
  localparam int NUM_REGS = 8;
  localparam int CNT_W = 5;
  // Read register selects (low three address bits)
  localparam logic [2:0] RD_STATUS = 3'h0;
  localparam logic [2:0] RD_FAULT0 = 3'h1;
  localparam logic [2:0] RD_FAULT1 = 3'h2;
  localparam logic [2:0] RD_DIAG = 3'h3;
  localparam logic [2:0] RD_CONFIG = 3'h4;
  // Write address of the global config register
  localparam logic [3:0] WR_CFG = 4'h0;
  // Config field positions
  localparam int CFG_SENSE_LO = 0;
  localparam int CFG_SENSE_HI = 1;
  localparam int CFG_TRACK = 2;
  localparam int CFG_PWM0 = 3;
  localparam int CFG_PWM1 = 4;
  localparam logic [15:0] CFG_RST = 16'h0000;
  // Fault vector positions
  localparam int F_OVERCUR = 0;
  localparam int F_OVERTEMP = 1;
  localparam int F_SHORT_VPWR = 2;
  localparam int F_SEVERE = 3;
  localparam int F_OPEN_ON = 4;
  localparam int F_OPEN_OFF = 5;
  localparam int F_CLK = 6;
  localparam int F_OVERVOLT = 7;
  localparam int F_UNDERVOLT = 8;
  localparam int NFAULT = 9;
  // Timing
  localparam int CLK_HZ = 100_000_000;
  localparam int WDTO_MS = 310;
  localparam int WDTO_CYC = WDTO_MS * (CLK_HZ / 1000);
  localparam int SLEEP_US = 100;
  localparam int SLEEP_CYC = SLEEP_US * (CLK_HZ / 1_000_000);
  localparam int CLKMON_US = 2000;
  localparam int CLKMON_CYC = CLKMON_US * (CLK_HZ / 1_000_000);
  typedef enum logic [2:0] {
    SWCSP_SLEEP = 3'b001,
    SWCSP_NORMAL = 3'b010,
    SWCSP_FAILSAFE = 3'b100
  } swcsp_mode_t;
endpackage : swcsp_pkg

// File: rtl/swcsp_sync.sv
`timescale 1ns/1ps
`default_nettype none
module swcsp_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } swcsp_sync_t;
  swcsp_sync_t st_ff, nxt_st;
  // Two-stage synchroniser; only s2 is read outside
  always_comb begin
    nxt_st.s1 = d;
    nxt_st.s2 = st_ff.s1;
  end
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign q = st_ff.s2;
endmodule : swcsp_sync
`default_nettype wire

// File: dv/swcsp_props.sv
`timescale 1ns/1ps
`default_nettype none
module swcsp_props
  import swcsp_pkg::*;
#(
  parameter int WDTO_CYCLES = 2000
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_wake_n,
  input wire logic chip_select_n,
  input wire logic [1:0] direct_in,
  input wire logic [1:0] load_type_select,
  input wire logic [swcsp_pkg::NFAULT-1:0] fault_events_ch0,
  input wire logic [1:0] overcur_window_active,
  input wire logic [1:0] motor_profile,
  input wire logic [1:0] sense_enable,
  input wire logic sense_oe,
  input wire logic fault_flag_n_out,
  input wire logic fault_flag_n_oe,
  input wire logic sdo_oe,
  input wire logic failsafe,
  input wire logic asleep,
  input wire logic [15:0] global_config_reg
);
  localparam int WD_LIM = WDTO_CYCLES + 20;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  int idle_ff;
  logic cs_ff;
  // Cycles since wake or the last frame end, saturating
  always_ff @(posedge clk) begin
    cs_ff <= chip_select_n;
    if (!nrst || !reset_wake_n || (chip_select_n && !cs_ff))
      idle_ff <= 0;
    else if (idle_ff < WD_LIM)
      idle_ff <= idle_ff + 1;
  end
  // Pin and output relations
  load_profile_a: assert property (motor_profile == load_type_select)
    else $error("profile differs from load type");
  sense_tri_a: assert property (global_config_reg[1:0] == 2'h0 |-> !sense_oe)
    else $error("sense driven with selects clear");
  sense_ocw_a: assert property ((overcur_window_active & sense_enable) == 2'h0)
    else $error("sense on in overcurrent window");
  sdo_idle_a: assert property (chip_select_n [*4] |-> !sdo_oe)
    else $error("sdo driven while deselected");
  flag_set_a: assert property (|fault_events_ch0 |-> ##[1:3] fault_flag_n_oe)
    else $error("fault flag not raised");
  flag_drive_a: assert property (fault_flag_n_oe |-> !fault_flag_n_out)
    else $error("fault flag driven high");
  wake_dir_a: assert property (asleep && $rose(direct_in[0]) |-> ##[1:6] !asleep)
    else $error("no wake on direct input");
  reg_hold_a: assert property (!reset_wake_n [*4] |-> global_config_reg == CFG_RST)
    else $error("config not held in reset");
  wd_expire_a: assert property (idle_ff == WD_LIM |-> failsafe)
    else $error("watchdog did not expire");
  // Main scenarios reached
  cov_fs: cover property ($rose(failsafe));
  cov_sleep: cover property ($rose(asleep));
  cov_flag: cover property ($rose(fault_flag_n_oe));
endmodule : swcsp_props
bind swcsp_top swcsp_props #(.WDTO_CYCLES(WDTO_CYCLES)) u_props (.*);
`default_nettype wire

// File: dv/swcsp_host.sv
`timescale 1ns/1ps
`default_nettype none
module swcsp_host (
  input wire logic clk,
  input wire logic sdo,
  input wire logic sdo_oe,
  output logic chip_select_n,
  output logic sclk,
  output logic sdi
);
  logic wd_bit;
  logic so_line;
  // Released data line shows the inverse of the last bit
  assign so_line = sdo_oe ? sdo : ~sdo;
  // Idle pins
  initial begin
    chip_select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
    wd_bit = 1'b0;
  end
  // One 32-bit frame: chained word first, then this device's word
  task automatic xfer(input logic [15:0] w, output logic [31:0] q);
    logic [31:0] d;
    d = {16'hc35a, wd_bit, w[14:0]};
    wd_bit = ~wd_bit;
    @(negedge clk);
    chip_select_n = 1'b0;
    sdi = d[31];
    repeat (6) @(negedge clk);
    for (int i = 31; i >= 0; i--) begin
      sclk = 1'b1;
      repeat (4) @(negedge clk);
      q[i] = so_line;
      sclk = 1'b0;
      repeat (2) @(negedge clk);
      sdi = (i > 0) ? d[i - 1] : 1'b0;
      repeat (2) @(negedge clk);
    end
    chip_select_n = 1'b1;
    repeat (10) @(negedge clk);
  endtask : xfer
endmodule : swcsp_host
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import swcsp_pkg::*;
  logic clk, nrst, reset_wake_n, sclk, sdi, chip_select_n, pwm_clock;
  logic [1:0] direct_in, load_type_select, overcur_window_active, pwm_ch_on;
  logic [NFAULT-1:0] fault_events_ch0, fault_events_ch1;
  logic sdo, sdo_oe, sense_track_hold, sense_hold, sense_oe, fault_flag_n_out;
  logic fault_flag_n_oe, sync_out, sync_oe, failsafe, asleep;
  logic [1:0] channel_on, motor_profile, sense_enable;
  logic [15:0] global_config_reg;
  logic [31:0] q;
  int errors, num_checks;
  logic [15:0] clr_w [5] = '{16'h1000, 16'h0200, 16'h0400, 16'h0600, 16'h0800};
  swcsp_top #(.WDTO_CYCLES(2000), .CLKMON_CYCLES(200)) i_dut (.*);
  swcsp_host i_host (.*);
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // Hang guard
  initial begin
    #600_000;
    errors++;
    end_of_test;
  end
  // Test sequence
  initial begin
    errors = 0;
    num_checks = 0;
    nrst = 1'b0;
    reset_wake_n = 1'b0;
    pwm_clock = 1'b0;
    pwm_ch_on = 2'h0;
    direct_in = 2'h0;
    load_type_select = 2'h3;
    overcur_window_active = 2'h0;
    fault_events_ch0 = '0;
    fault_events_ch1 = '0;
    tick(12);
    nrst = 1'b1;
    tick(3);
    check("asleep", asleep, 1'b1);
    reset_wake_n = 1'b1;
    tick(8);
    check("awake", asleep, 1'b0);
    for (int i = 0; i < 4; i++) begin
      load_type_select = i[1:0];
      direct_in = i[1:0];
      tick(6);
      check("motor_profile", motor_profile, i[1:0]);
      check("channel_on", channel_on, i[1:0]);
    end
    i_host.xfer(16'h0003, q);
    check("config", global_config_reg[4:0], 5'h03);
    check("sync_low", sync_oe, 1'b1);
    overcur_window_active = 2'h3;
    i_host.xfer(16'h0800, q);
    i_host.xfer(16'h0800, q);
    check("readback", q[31:16], 16'h0003);
    check("chain", q[15:0], 16'hc35a);
    overcur_window_active = 2'h0;
    i_host.xfer(16'h0004, q);
    check("sense_oe", sense_oe, 1'b0);
    check("track_hold", sense_track_hold, 1'b1);
    direct_in = 2'h0;
    tick(6);
    check("sense_hold", sense_hold, 1'b1);
    // Every fault kind raises the flag; reading clears it
    for (int f = 0; f < NFAULT; f++) begin
      fault_events_ch0 = NFAULT'(1) << f;
      fault_events_ch1 = NFAULT'(1) << f;
      tick(1);
      fault_events_ch0 = '0;
      fault_events_ch1 = '0;
      tick(3);
      check("flag_set", fault_flag_n_oe, 1'b1);
      foreach (clr_w[k]) i_host.xfer(clr_w[k], q);
      check("flag_clear", fault_flag_n_oe, 1'b0);
    end
    i_host.xfer(16'h0008, q);
    pwm_ch_on = 2'h1;
    tick(300);
    check("clock_fail", fault_flag_n_oe, 1'b1);
    check("pwm_channel", channel_on, 2'h1);
    tick(1600);
    check("no_failsafe", failsafe, 1'b0);
    tick(200);
    check("failsafe", failsafe, 1'b1);
    direct_in = 2'h3;
    tick(6);
    check("fs_channel", channel_on, 2'h3);
    reset_wake_n = 1'b0;
    direct_in = 2'h0;
    tick(SLEEP_CYC + 50);
    check("sleep", asleep, 1'b1);
    check("cfg_reset", global_config_reg, CFG_RST);
    direct_in = 2'h1;
    tick(8);
    check("wake", asleep, 1'b0);
    end_of_test;
  end
endmodule : testbench
`default_nettype wire
